// File: rtl/xdf_front_end.sv
// rtl: x86 predecode, decoders, microcode rom and operation scheduler
module xdf_front_end
    import xdf_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // instruction cache fill, one byte per beat
    input wire logic fill_vld,
    input wire logic [7:0] fill_byte,
    output logic fill_rdy,
    // execution pipelines
    input wire logic [PIPES-1:0] pipe_rdy,
    input wire logic [PIPES-1:0] pipe_done,
    input wire logic [PIPES-1:0][4:0] pipe_tag,
    output logic [PIPES-1:0] iss_vld,
    output xdf_op_t [PIPES-1:0] iss_op,
    output logic [PIPES-1:0][4:0] iss_tag,
    // status
    output logic [2:0] retire_cnt,
    output logic [4:0] occ,
    output logic [2:0] dec_kind
);

////////////////////////////////////////////////////////////////////////////
// decode helpers

// length of an instruction from its first byte
function automatic logic [3:0] len_of(input logic [7:0] b);
    return (b[3:0] == LEN_ESC) ? LEN_ESC : b[3:0] + 4'h1;
endfunction

// one or two ops; memory source splits into load first
function automatic xdf_grp_t short_ops(input logic [7:0] b);
    xdf_grp_t o;
    o = '0;
    if (b[7])
    begin
        o[0] = '{1'b1, CAT_LOAD, TMP_REG, {2'h0, b[3:0]}};
        o[1] = '{1'b1, xdf_cat_t'(b[6:4]), {2'h0, b[3:0]}, TMP_REG};
    end
    else
        o[0] = '{1'b1, xdf_cat_t'(b[6:4]), {2'h0, b[3:0]}, {2'h0, b[3:0]}};
    return o;
endfunction

// up to four ops, count from the second byte
function automatic xdf_grp_t long_ops(input logic [7:0] b,
    input logic [7:0] c);
    xdf_grp_t o;
    o = '0;
    for (int k = 0; k < GRP; k++)
        if (k <= int'(c[1:0]))
        begin
            o[k].vld = 1'b1;
            o[k].cat = (k == 0 && b[7]) ? CAT_LOAD : xdf_cat_t'(b[6:4]);
            o[k].dst = (k == 0 && b[7]) ? TMP_REG : c[7:2];
            o[k].src = (k != 0 && b[7]) ? TMP_REG : c[7:2];
        end
    return o;
endfunction

// vector entry group and rom groups, always four ops
function automatic xdf_grp_t rom_ops(input logic [5:0] a, input logic [2:0] c);
    xdf_grp_t o;
    o = '0;
    for (int k = 0; k < GRP; k++)
        o[k] = '{1'b1, xdf_cat_t'(c ^ 3'(k)), a, {a[5:2], 2'(k)}};
    return o;
endfunction

////////////////////////////////////////////////////////////////////////////
// state and next state

xdf_state_t s, next_s;
xdf_grp_t grp, grp2;
xdf_kind_t kind;
logic wr, ret, room;
logic [5:0] used;
logic [7:0] b0, b1;
logic [3:0] len0, len1;
logic [4:0] r2, hb, tb;
logic [PIPES-1:0] taken;
int li, idx, p;

// outputs straight from the state register
assign fill_rdy = s.fill_rdy;
assign iss_vld = s.iss_vld;
assign iss_op = s.iss_op;
assign iss_tag = s.iss_tag;
assign retire_cnt = s.retire_cnt;
assign occ = s.occ;
assign dec_kind = s.kind;

// next state: fill, predecode, decode, rom, scheduler
always_comb
begin
    next_s = s;
    grp = '0;
    kind = K_NONE;
    wr = 1'b0;
    used = '0;
    taken = '0;
    li = 0;
    idx = 0;
    p = 0;
    b0 = s.byt[s.rptr];
    b1 = s.byt[5'(s.rptr + 5'h1)];
    len0 = s.plen[s.rptr];
    r2 = 5'(s.rptr + 5'(len0));
    len1 = s.plen[r2];
    grp2 = short_ops(s.byt[r2]);
    room = s.lines < 3'(LINES);
    hb = 5'({s.head, 2'b00});
    tb = 5'({s.tail, 2'b00});
    ret = (s.lines != 3'h0) && (&s.done[hb +: GRP]);

    // byte-serial predecode as the cache fills
    if (fill_vld && s.fill_rdy)
    begin
        next_s.byt[s.wptr] = fill_byte;
        next_s.pstart[s.wptr] = (s.pd_left == 4'h0);
        next_s.plen[s.wptr] = len_of(fill_byte);
        next_s.pd_left = (s.pd_left == 4'h0) ? len_of(fill_byte) - 4'h1
                                              : s.pd_left - 4'h1;
        next_s.wptr = s.wptr + 5'h1;
    end

    // decoder: one choice per slot, or rom continuation
    case (s.st)
        ST_DEC:
        begin
            if (room && s.pstart[s.rptr] && s.cnt >= 6'(len0))
            begin
                wr = 1'b1;
                used = 6'(len0);
                if (len0 > 4'(LONG_MAX))
                begin
                    kind = K_VEC;
                    grp = rom_ops(b1[5:0], b0[6:4]);
                    next_s.rom_addr = b1[5:0] + 6'h1;
                    next_s.rom_left = {1'b0, b1[7:6]} + 3'h1;
                    next_s.st = ST_ROM;
                end
                else if (len0 > 4'(SHORT_MAX))
                begin
                    kind = K_LONG;
                    grp = long_ops(b0, b1);
                end
                else
                begin
                    kind = K_SHORT;
                    grp = short_ops(b0);
                    if (s.cnt > 6'(len0) && s.pstart[r2]
                        && len1 <= 4'(SHORT_MAX)
                        && s.cnt >= 6'(len0) + 6'(len1))
                    begin
                        grp[3:2] = grp2[1:0];
                        used = 6'(len0) + 6'(len1);
                    end
                end
            end
        end
        ST_ROM:
        begin
            if (room)
            begin
                wr = 1'b1;
                grp = rom_ops(s.rom_addr, s.rom_addr[2:0]);
                next_s.rom_addr = s.rom_addr + 6'h1;
                next_s.rom_left = s.rom_left - 3'h1;
                if (s.rom_left == 3'h1)
                    next_s.st = ST_DEC;
            end
        end
        default: next_s.st = ST_DEC;
    endcase
    next_s.rptr = s.rptr + used[4:0];
    next_s.cnt = s.cnt + 6'(fill_vld && s.fill_rdy) - used;
    next_s.fill_rdy = next_s.cnt < 6'(BUF_BYTES);
    next_s.kind = kind;

    // completions reported by the pipelines
    for (int q = 0; q < PIPES; q++)
        if (pipe_done[q])
            next_s.done[pipe_tag[q]] = 1'b1;

    // in-order retirement of one whole line
    next_s.retire_cnt = '0;
    if (ret)
    begin
        for (int k = 0; k < GRP; k++)
        begin
            next_s.retire_cnt = next_s.retire_cnt
                                + 3'(s.ent[hb + 5'(k)].vld);
            next_s.ent[hb + 5'(k)] = '0;
        end
        next_s.head = (s.head == 3'(LINES - 1)) ? 3'h0 : s.head + 3'h1;
    end

    // group written into the free line at the tail
    if (wr)
    begin
        for (int k = 0; k < GRP; k++)
        begin
            next_s.ent[tb + 5'(k)] = grp[k];
            next_s.iss[tb + 5'(k)] = 1'b0;
            next_s.done[tb + 5'(k)] = !grp[k].vld || grp[k].cat == CAT_LDI;
        end
        next_s.tail = (s.tail == 3'(LINES - 1)) ? 3'h0 : s.tail + 3'h1;
    end
    next_s.lines = s.lines + 3'(wr) - 3'(ret);

    // oldest-first issue, one op per pipeline per clock
    next_s.iss_vld = '0;
    for (int k = 0; k < SCHED_OPS; k++)
    begin
        li = (int'(s.head) + k / GRP) % LINES;
        idx = li * GRP + k % GRP;
        case (s.ent[idx].cat)
            CAT_LOAD: p = P_LOAD;
            CAT_STORE: p = P_STORE;
            CAT_FP: p = P_FP;
            CAT_BR: p = P_BR;
            default: p = (taken[P_X] || !pipe_rdy[P_X]) ? P_Y : P_X;
        endcase
        if (k / GRP < int'(s.lines) && s.ent[idx].vld && !s.iss[idx]
            && s.ent[idx].cat != CAT_LDI && !taken[p] && pipe_rdy[p])
        begin
            taken[p] = 1'b1;
            next_s.iss_vld[p] = 1'b1;
            next_s.iss_op[p] = s.ent[idx];
            next_s.iss_tag[p] = 5'(idx);
            next_s.iss[idx] = 1'b1;
        end
    end

    // occupancy of the buffer
    next_s.occ = '0;
    for (int k = 0; k < SCHED_OPS; k++)
        next_s.occ = next_s.occ + 5'(next_s.ent[k].vld);
end

// state register
always_ff @(posedge ref_clk or negedge arst_n)
begin
    if (!arst_n)
    begin
        s <= '0;
        s.st <= ST_DEC;
    end
    else
        s <= next_s;
end

////////////////////////////////////////////////////////////////////////////
// checks

default clocking cb @(posedge ref_clk);
endclocking
default disable iff (!arst_n);

pd_mark_a: assert property (
    fill_vld && s.fill_rdy && s.pd_left == 4'h0
    |=> s.pstart[$past(s.wptr)]
        && s.plen[$past(s.wptr)] == len_of($past(fill_byte)))
    else $error("start byte not marked by predecode");
pd_used_a: assert property (
    wr && s.st == ST_DEC |-> s.pstart[s.rptr] && s.cnt >= 6'(len0))
    else $error("decode without predecode start");
slot_choice_a: assert property (
    wr && s.st == ST_DEC |=> $onehot(s.kind))
    else $error("decode slot not exactly one choice");
short_len_a: assert property (
    wr && kind == K_SHORT |-> len0 <= 4'(SHORT_MAX) && grp[0].vld)
    else $error("short decode out of range");
pair_used_a: assert property (
    wr && kind == K_SHORT && grp[2].vld |-> used == 6'(len0) + 6'(len1))
    else $error("paired short decode consumed wrong bytes");
long_len_a: assert property (
    wr && kind == K_LONG
    |-> len0 > 4'(SHORT_MAX) && len0 <= 4'(LONG_MAX) && grp[0].vld)
    else $error("long decode out of range");
vec_rom_a: assert property (
    wr && kind == K_VEC |-> &{grp[3].vld, grp[0].vld} ##1 s.st == ST_ROM)
    else $error("vectored decode did not enter rom");
rom_rate_a: assert property (
    s.st == ST_ROM && room |-> wr && grp[0].vld && grp[3].vld)
    else $error("rom group not emitted");
line_write_a: assert property (
    wr && !ret |=> s.lines == $past(s.lines) + 3'h1)
    else $error("group not written into a line");
len_range_a: assert property (
    s.pstart[s.rptr] |-> len0 >= 4'(MIN_LEN) && len0 <= 4'(MAX_LEN))
    else $error("instruction length out of range");
load_route_a: assert property (
    s.iss_vld[P_LOAD] |-> s.iss_op[P_LOAD].cat == CAT_LOAD)
    else $error("non-load op on load pipeline");
cmp_split_a: assert property (
    wr && kind == K_SHORT && b0[7]
    |-> grp[0].cat == CAT_LOAD && grp[1].src == TMP_REG)
    else $error("memory source op not split");
xy_route_a: assert property (
    s.iss_vld[P_Y] |-> s.iss_op[P_Y].cat inside {CAT_INT, CAT_MM, CAT_V3D})
    else $error("wrong op on register pipeline");
occ_max_a: assert property (
    s.occ <= 5'(SCHED_OPS) && s.lines <= 3'(LINES))
    else $error("scheduler over capacity");
retire_max_a: assert property (
    s.retire_cnt <= 3'(RETIRE_MAX))
    else $error("too many ops retired");
line_stall_a: assert property (
    !room && s.st == ST_DEC |=> $stable(s.rptr) && s.kind == K_NONE)
    else $error("decoder advanced with no free line");

pair_c: cover property (wr && kind == K_SHORT && grp[2].vld);
vec_c: cover property (s.st == ST_ROM && room ##1 s.st == ST_DEC);
full_c: cover property (s.lines == 3'(LINES));
six_issue_c: cover property (&s.iss_vld);
endmodule

// File: inc/xdf_pkg.sv
// package: types and constants of the x86 decode front end
package xdf_pkg;
    localparam int BUF_BYTES = 32;
    localparam int MIN_LEN = 1;
    localparam int MAX_LEN = 15;
    localparam int SHORT_MAX = 7;
    localparam int LONG_MAX = 11;
    localparam int GRP = 4;
    localparam int LINES = 6;
    localparam int SCHED_OPS = 24;
    localparam int PIPES = 6;
    localparam int RETIRE_MAX = 4;
    localparam int P_LOAD = 0;
    localparam int P_STORE = 1;
    localparam int P_X = 2;
    localparam int P_Y = 3;
    localparam int P_FP = 4;
    localparam int P_BR = 5;
    localparam logic [3:0] LEN_ESC = 4'hf;
    localparam logic [5:0] TMP_REG = 6'h30;

    // operation categories; int, mm and v3d share the x/y pipelines and ldi is never issued
    typedef enum logic [2:0] {
        CAT_LOAD = 3'h0, CAT_LDI = 3'h1, CAT_STORE = 3'h2, CAT_INT = 3'h3,
        CAT_MM = 3'h4, CAT_V3D = 3'h5, CAT_FP = 3'h6, CAT_BR = 3'h7
    } xdf_cat_t;

    // fixed-length internal operation, 64-entry register space
    typedef struct packed {
        logic vld;
        xdf_cat_t cat;
        logic [5:0] dst;
        logic [5:0] src;
    } xdf_op_t;

    typedef xdf_op_t [GRP-1:0] xdf_grp_t;

    typedef enum logic [2:0] {
        K_NONE = 3'b000, K_SHORT = 3'b001, K_LONG = 3'b010, K_VEC = 3'b100
    } xdf_kind_t;

    typedef enum logic [1:0] {ST_DEC = 2'b01, ST_ROM = 2'b10} xdf_st_t;

    // whole state of the front end
    typedef struct packed {
        logic [BUF_BYTES-1:0][7:0] byt;
        logic [BUF_BYTES-1:0] pstart;
        logic [BUF_BYTES-1:0][3:0] plen;
        logic [4:0] wptr;
        logic [4:0] rptr;
        logic [5:0] cnt;
        logic [3:0] pd_left;
        logic fill_rdy;
        xdf_st_t st;
        logic [5:0] rom_addr;
        logic [2:0] rom_left;
        xdf_op_t [SCHED_OPS-1:0] ent;
        logic [SCHED_OPS-1:0] iss;
        logic [SCHED_OPS-1:0] done;
        logic [2:0] head;
        logic [2:0] tail;
        logic [2:0] lines;
        logic [PIPES-1:0] iss_vld;
        xdf_op_t [PIPES-1:0] iss_op;
        logic [PIPES-1:0][4:0] iss_tag;
        logic [2:0] retire_cnt;
        logic [4:0] occ;
        xdf_kind_t kind;
    } xdf_state_t;
endpackage

// File: verification/xdf_pipes.sv
// partner: execution pipelines that take issued ops and report completion
module xdf_pipes
    import xdf_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // behaviour controls from the bench
    input wire logic slow,
    input wire logic hold,
    // issue side
    input wire logic [PIPES-1:0] iss_vld,
    input wire logic [PIPES-1:0][4:0] iss_tag,
    // completion side
    output logic [PIPES-1:0] pipe_rdy,
    output logic [PIPES-1:0] pipe_done,
    output logic [PIPES-1:0][4:0] pipe_tag
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [PIPES-1:0] busy;
    logic [PIPES-1:0][1:0] wait_c;
    logic [PIPES-1:0][4:0] held;

    ////////////////////////////////////////////////////////////////////////
    // ready drops at once when slow, so one op at a time is in flight
    assign pipe_rdy = ~busy & ~(iss_vld & {PIPES{slow}}) & {PIPES{~hold}};

    // completion one cycle after issue, or four when slow
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            busy <= '0;
            wait_c <= '0;
            held <= '0;
            pipe_done <= '0;
            pipe_tag <= '0;
        end
        else
        begin
            for (int p = 0; p < PIPES; p++)
            begin
                pipe_done[p] <= 1'b0;
                pipe_tag[p] <= ~pipe_tag[p]; // tag is stale outside done
                if (iss_vld[p] && !slow)
                begin
                    pipe_done[p] <= 1'b1;
                    pipe_tag[p] <= iss_tag[p];
                end
                else if (iss_vld[p])
                begin
                    busy[p] <= 1'b1;
                    held[p] <= iss_tag[p];
                    wait_c[p] <= 2'h2;
                end
                else if (busy[p] && wait_c[p] == 2'h0)
                begin
                    pipe_done[p] <= 1'b1;
                    pipe_tag[p] <= held[p];
                    busy[p] <= 1'b0;
                end
                else if (busy[p])
                    wait_c[p] <= wait_c[p] - 2'h1;
            end
        end
    end
endmodule

// File: verification/testbench.sv
// testbench: decode front end fed with fill bytes and a pipeline model
module testbench
    import xdf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic fill_vld = 1'b0;
    logic [7:0] fill_byte = 8'h00;
    logic slow = 1'b0;
    logic hold = 1'b0;
    logic fill_rdy;
    logic [PIPES-1:0] pipe_rdy, pipe_done, iss_vld;
    logic [PIPES-1:0][4:0] pipe_tag, iss_tag;
    xdf_op_t [PIPES-1:0] iss_op;
    logic [2:0] retire_cnt, dec_kind;
    logic [4:0] occ;
    int n_errors = 0;
    int tests_run = 0;
    int cycles = 0;
    // tallies: retired, load, store, x/y, fp, branch, short, long, vector
    logic [31:0] cnt [9] = '{default: 0};
    logic [31:0] base [9] = '{default: 0};
    bit [7:0] q [$];

    always #10 ref_clk = ~ref_clk;

    xdf_front_end u_xdf_front_end (.ref_clk(ref_clk), .arst_n(arst_n),
        .fill_vld(fill_vld), .fill_byte(fill_byte), .fill_rdy(fill_rdy),
        .pipe_rdy(pipe_rdy), .pipe_done(pipe_done), .pipe_tag(pipe_tag),
        .iss_vld(iss_vld), .iss_op(iss_op), .iss_tag(iss_tag),
        .retire_cnt(retire_cnt), .occ(occ), .dec_kind(dec_kind));
    xdf_pipes u_xdf_pipes (.ref_clk(ref_clk), .arst_n(arst_n), .slow(slow),
        .hold(hold), .iss_vld(iss_vld), .iss_tag(iss_tag),
        .pipe_rdy(pipe_rdy), .pipe_done(pipe_done), .pipe_tag(pipe_tag));

    ////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        tests_run++;
        if (exp !== got)
        begin
            n_errors++;
            $display("wrong value %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    // pipeline that each category must land on
    function automatic logic cat_ok(input int p, input xdf_cat_t c);
        case (p)
            P_LOAD: return c == CAT_LOAD;
            P_STORE: return c == CAT_STORE;
            P_FP: return c == CAT_FP;
            P_BR: return c == CAT_BR;
            default: return c inside {CAT_INT, CAT_MM, CAT_V3D};
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // tallies, per-cycle checks and the hang limit
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            conclude();
        end
        if (arst_n === 1'b1)
        begin
            cnt[0] += 32'(retire_cnt);
            for (int p = 0; p < PIPES; p++)
                if (iss_vld[p] === 1'b1)
                begin
                    cnt[p < 2 ? p + 1 : (p < 4 ? 3 : p)] += 1;
                    check("route", 1, cat_ok(p, iss_op[p].cat));
                end
            for (int k = 0; k < 3; k++)
                cnt[6 + k] += 32'(dec_kind[k] === 1'b1);
            check("decode choice", 1, $onehot0(dec_kind));
            check("occupancy", 1, occ <= 5'(SCHED_OPS));
            check("retire width", 1, retire_cnt <= 3'(RETIRE_MAX));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic add(input bit [7:0] b0, input bit [7:0] b1, input int len);
        q.push_back(b0);
        for (int i = 1; i < len; i++)
            q.push_back(i == 1 ? b1 : 8'h00);
    endtask

    // one byte per beat, held until taken
    task automatic send();
        foreach (q[i])
        begin
            fill_vld <= 1'b1;
            fill_byte <= q[i];
            do @(posedge ref_clk); while (fill_rdy !== 1'b1);
        end
        fill_vld <= 1'b0;
        q.delete();
    endtask

    // wait for retirement to reach its total, then compare tallies
    task automatic expect_cnt(input int e [9]);
        int w;
        w = 0;
        while (cnt[0] - base[0] < e[0] && w < 400)
        begin
            @(posedge ref_clk);
            w++;
        end
        check("retire wait", 1, w < 400);
        repeat (4) @(posedge ref_clk);
        for (int k = 0; k < 9; k++)
            if (k == 6 && e[6] > 0)
                check("short decodes", 1,
                    cnt[6] - base[6] inside {[(e[6] + 1) / 2 : e[6]]});
            else if (e[k] >= 0)
                check($sformatf("tally %0d", k), e[k], cnt[k] - base[k]);
        base = cnt;
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic s_short();
        for (int i = 0; i < 4; i++)
            add(8'h31, 8'(4 * i), 2);
        send();
        expect_cnt('{4, 0, 0, 4, 0, 0, 4, 0, 0});
    endtask

    task automatic s_cmp();
        add(8'hb1, 8'h05, 2);
        send();
        expect_cnt('{2, 1, 0, 1, 0, 0, 1, 0, 0});
    endtask

    task automatic s_cats();
        for (int c = 0; c < 8; c++)
            add(8'(c << 4), 8'h00, 1);
        send();
        expect_cnt('{8, 1, 1, 3, 1, 1, 8, 0, 0});
    endtask

    task automatic s_long();
        add(8'h37, 8'h03, 8);
        add(8'h3a, 8'h01, 11);
        send();
        expect_cnt('{6, -1, -1, -1, -1, -1, 0, 2, 0});
    endtask

    task automatic s_vec();
        add(8'h3f, 8'h45, 15);
        add(8'h3c, 8'h00, 13);
        send();
        expect_cnt('{20, -1, -1, -1, -1, -1, 0, 0, 2});
    endtask

    // pipelines blocked until the scheduler fills, then slow completion
    task automatic s_stall();
        logic [31:0] m;
        hold <= 1'b1;
        for (int i = 0; i < 14; i++)
            add(8'hb1, 8'(i), 2);
        send();
        repeat (30) @(posedge ref_clk);
        m = cnt[6];
        repeat (20) @(posedge ref_clk);
        check("stalled decode", m, cnt[6]);
        check("held retire", base[0], cnt[0]);
        check("held occupancy", 1, occ != 5'h00);
        slow <= 1'b1;
        hold <= 1'b0;
        expect_cnt('{28, 14, 0, 14, 0, 0, 14, 0, 0});
    endtask

    initial
    begin
        repeat (8) @(posedge ref_clk);
        arst_n <= 1'b1;
        @(posedge ref_clk);
        s_short();
        s_cmp();
        s_cats();
        s_long();
        s_vec();
        s_stall();
        conclude();
    end
endmodule
